// [design/iob_regs.vh]
// Register map, field positions and reset values of the pad buffer control block.
// Included by the top module. It holds definitions only.
`ifndef IOB_REGS_VH
`define IOB_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IOB_CTRL_OFS        12'h000
`define IOB_CAL_OFS         12'h004
`define IOB_STAT_OFS        12'h008
`define IOB_TERM_OFS        12'h00C

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define IOB_C_SE_OFF        0
`define IOB_C_SE_TERM_OFF   1
`define IOB_C_CAL_OFF       2
`define IOB_C_DO_OFF        3
`define IOB_C_DT_OFF        4
`define IOB_C_DT_TERM_OFF   5
`define IOB_C_DCO_OFF       6
`define IOB_C_DCT_TERM_OFF  7
`define IOB_C_DCAL_OFF      8
`define IOB_C_TRISTATE      9
`define IOB_C_HS_OFF        10
`define IOB_C_LP_OFF        11
`define IOB_C_DOUT          12
`define IOB_CTRL_W          13
`define IOB_CTRL_RST        13'h0200

// ----------------------------------------------------------------
// Calibration register fields
// ----------------------------------------------------------------
`define IOB_K_SE_EN         0
`define IOB_K_SE_VAL        4
`define IOB_K_D_EN          8
`define IOB_K_D_VAL         12
`define IOB_CAL_W           16
`define IOB_CAL_RST         16'h0000

// ----------------------------------------------------------------
// Status widths and bus constants
// ----------------------------------------------------------------
`define IOB_STAT_W          16
`define IOB_TERM_W          4
`define IOB_PAD_W           19
`define IOB_SYNC_STAGES     2

`endif

// [design/iob_sync.v]
// Two flip-flop synchroniser for a bundle of pad levels.
// Assumes inputs are asynchronous to pclk; only the second stage is read outside.
`timescale 1ns/1ns
module iob_sync #(
  parameter WIDTH = 1
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// [design/iob_diff_rx.v]
// Differential receiver with optional input-off gating and complementary output.
// Assumes synchronised pad levels; the pair reads high when true high and bar low.
`timescale 1ns/1ns
module iob_diff_rx #(
  parameter HONOR_OFF = 1
) (
  input  wire pad,
  input  wire padb,
  input  wire input_off,
  output wire fabric_out,
  output wire fabric_out_inverted
);

  wire rx;
  wire kill;

  assign rx   = pad & ~padb;
  // Off gating is wired out entirely when the variant ignores it
  assign kill = (HONOR_OFF != 0) & input_off;
  assign fabric_out          = rx & ~kill;
  assign fabric_out_inverted = ~rx & ~kill;

endmodule

// [design/iob_top.v]
// Pad buffer control block: single-ended, differential, D-PHY and bidirectional
// buffers with input-off, termination-off, offset calibration and three-state control.
// Assumes an APB master on pclk and pad levels asynchronous to pclk.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "iob_regs.vh"
module iob_top #(
  parameter USE_INPUT_OFF_ATTR = 1
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        se_term_pad,
  input  wire        se_cal_pad,
  input  wire        d0_pad,
  input  wire        d0_padb,
  input  wire        d1_pad,
  input  wire        d1_padb,
  input  wire        d2_pad,
  input  wire        d2_padb,
  input  wire        d3_pad,
  input  wire        d3_padb,
  input  wire        d4_pad,
  input  wire        d4_padb,
  input  wire        d5_pad,
  input  wire        d5_padb,
  input  wire        d6_pad,
  input  wire        d6_padb,
  input  wire        dphy_pad,
  input  wire        dphy_padb,
  input  wire        bidir_pad_in,
  output reg         bidir_pad_out,
  output reg         bidir_pad_oe,
  output reg         se_term_fabric_out,
  output reg         se_term_on,
  output reg         se_cal_fabric_out,
  output reg         se_offset_cal_enable,
  output reg  [3:0]  se_offset_cal_value,
  output reg         d0_fabric_out,
  output reg         d1_fabric_out,
  output reg         d1_fabric_out_inverted,
  output reg         d2_fabric_out,
  output reg         d2_fabric_out_inverted,
  output reg         d3_fabric_out,
  output reg         d3_fabric_out_inverted,
  output reg         d3_term_on,
  output reg         d4_fabric_out,
  output reg         d5_fabric_out,
  output reg         d5_term_on,
  output reg         d6_fabric_out,
  output reg  [1:0]  d6_offset_cal_enable,
  output reg  [3:0]  d6_offset_cal_value,
  output reg         hs_receiver_out,
  output reg  [1:0]  lp_receiver_out,
  output reg         bidir_fabric_out,
  output reg         bidir_term_on
);

  // ----------------------------------------------------------------
  // Byte-lane merge for writes
  // ----------------------------------------------------------------
  function [31:0] iob_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer i;
    begin
      iob_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          iob_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Pad synchronisation
  // ----------------------------------------------------------------
  wire [`IOB_PAD_W-1:0] pad_s;

  iob_sync #(
    .WIDTH (`IOB_PAD_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({bidir_pad_in, dphy_padb, dphy_pad, d6_padb, d6_pad, d5_padb, d5_pad,
                d4_padb, d4_pad, d3_padb, d3_pad, d2_padb, d2_pad, d1_padb, d1_pad,
                d0_padb, d0_pad, se_cal_pad, se_term_pad}),
    .sync_out (pad_s)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [`IOB_CTRL_W-1:0] ctrl_r;
  reg  [`IOB_CAL_W-1:0]  cal_r;
  wire [31:0]            ctrl_nxt;
  wire [31:0]            cal_nxt;
  wire                   wr_go;
  wire                   sel_ctrl;
  wire                   sel_cal;
  wire                   sel_stat;
  wire                   sel_term;
  wire                   mapped;

  assign sel_ctrl = (paddr == `IOB_CTRL_OFS);
  assign sel_cal  = (paddr == `IOB_CAL_OFS);
  assign sel_stat = (paddr == `IOB_STAT_OFS);
  assign sel_term = (paddr == `IOB_TERM_OFS);
  assign mapped   = sel_ctrl | sel_cal | sel_stat | sel_term;
  assign wr_go    = psel & penable & pready & pwrite;
  assign ctrl_nxt = iob_merge({{(32-`IOB_CTRL_W){1'b0}}, ctrl_r}, pwdata, pstrb);
  assign cal_nxt  = iob_merge({{(32-`IOB_CAL_W){1'b0}}, cal_r}, pwdata, pstrb);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `IOB_CTRL_RST;
      cal_r  <= `IOB_CAL_RST;
    end else if (wr_go) begin
      if (sel_ctrl) begin
        ctrl_r <= ctrl_nxt[`IOB_CTRL_W-1:0];
      end
      if (sel_cal) begin
        cal_r <= cal_nxt[`IOB_CAL_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  wire attr_on;
  wire se_off;
  wire cal_off;
  wire do_off;
  wire dt_off;
  wire dcal_off;
  wire tristate;

  assign attr_on  = (USE_INPUT_OFF_ATTR != 0);
  assign se_off   = attr_on & ctrl_r[`IOB_C_SE_OFF];
  assign cal_off  = attr_on & ctrl_r[`IOB_C_CAL_OFF];
  assign do_off   = attr_on & ctrl_r[`IOB_C_DO_OFF];
  assign dt_off   = attr_on & ctrl_r[`IOB_C_DT_OFF];
  assign dcal_off = attr_on & ctrl_r[`IOB_C_DCAL_OFF];
  assign tristate = ctrl_r[`IOB_C_TRISTATE];

  // ----------------------------------------------------------------
  // Differential receivers
  // ----------------------------------------------------------------
  wire d0_o;
  wire d1_o;
  wire d1_i;
  wire d2_o;
  wire d2_i;
  wire d3_o;
  wire d3_i;
  wire d4_o;
  wire d5_o;
  wire d6_o;
  wire hs_o;

  iob_diff_rx #(.HONOR_OFF (0)) u_d0 (
    .pad                 (pad_s[2]),
    .padb                (pad_s[3]),
    .input_off           (1'b0),
    .fabric_out          (d0_o),
    .fabric_out_inverted ()
  );

  iob_diff_rx #(.HONOR_OFF (0)) u_d1 (
    .pad                 (pad_s[4]),
    .padb                (pad_s[5]),
    .input_off           (1'b0),
    .fabric_out          (d1_o),
    .fabric_out_inverted (d1_i)
  );

  // Off level is stored and read back but has no effect on the receiver
  iob_diff_rx #(.HONOR_OFF (0)) u_d2 (
    .pad                 (pad_s[6]),
    .padb                (pad_s[7]),
    .input_off           (ctrl_r[`IOB_C_DCO_OFF]),
    .fabric_out          (d2_o),
    .fabric_out_inverted (d2_i)
  );

  iob_diff_rx #(.HONOR_OFF (0)) u_d3 (
    .pad                 (pad_s[8]),
    .padb                (pad_s[9]),
    .input_off           (ctrl_r[`IOB_C_DCO_OFF]),
    .fabric_out          (d3_o),
    .fabric_out_inverted (d3_i)
  );

  iob_diff_rx #(.HONOR_OFF (1)) u_d4 (
    .pad                 (pad_s[10]),
    .padb                (pad_s[11]),
    .input_off           (do_off),
    .fabric_out          (d4_o),
    .fabric_out_inverted ()
  );

  iob_diff_rx #(.HONOR_OFF (1)) u_d5 (
    .pad                 (pad_s[12]),
    .padb                (pad_s[13]),
    .input_off           (dt_off),
    .fabric_out          (d5_o),
    .fabric_out_inverted ()
  );

  iob_diff_rx #(.HONOR_OFF (1)) u_d6 (
    .pad                 (pad_s[14]),
    .padb                (pad_s[15]),
    .input_off           (dcal_off),
    .fabric_out          (d6_o),
    .fabric_out_inverted ()
  );

  iob_diff_rx #(.HONOR_OFF (1)) u_hs (
    .pad                 (pad_s[16]),
    .padb                (pad_s[17]),
    .input_off           (ctrl_r[`IOB_C_HS_OFF]),
    .fabric_out          (hs_o),
    .fabric_out_inverted ()
  );

  // ----------------------------------------------------------------
  // Output stage: one flop after the combinational gating
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      se_term_fabric_out     <= 1'b0;
      se_term_on             <= 1'b1;
      se_cal_fabric_out      <= 1'b0;
      se_offset_cal_enable   <= 1'b0;
      se_offset_cal_value    <= 4'h0;
      d0_fabric_out          <= 1'b0;
      d1_fabric_out          <= 1'b0;
      d1_fabric_out_inverted <= 1'b0;
      d2_fabric_out          <= 1'b0;
      d2_fabric_out_inverted <= 1'b0;
      d3_fabric_out          <= 1'b0;
      d3_fabric_out_inverted <= 1'b0;
      d3_term_on             <= 1'b1;
      d4_fabric_out          <= 1'b0;
      d5_fabric_out          <= 1'b0;
      d5_term_on             <= 1'b1;
      d6_fabric_out          <= 1'b0;
      d6_offset_cal_enable   <= 2'h0;
      d6_offset_cal_value    <= 4'h0;
      hs_receiver_out        <= 1'b0;
      lp_receiver_out        <= 2'h0;
      bidir_fabric_out       <= 1'b0;
      bidir_term_on          <= 1'b1;
      bidir_pad_out          <= 1'b0;
      bidir_pad_oe           <= 1'b0;
    end else begin
      se_term_fabric_out     <= pad_s[0] & ~se_off;
      se_term_on             <= ~ctrl_r[`IOB_C_SE_TERM_OFF];
      // Reference tuning is not a port of this buffer
      se_cal_fabric_out      <= pad_s[1] & ~cal_off;
      se_offset_cal_enable   <= cal_r[`IOB_K_SE_EN];
      se_offset_cal_value    <= cal_r[`IOB_K_SE_VAL +: 4];
      d0_fabric_out          <= d0_o;
      d1_fabric_out          <= d1_o;
      d1_fabric_out_inverted <= d1_i;
      d2_fabric_out          <= d2_o;
      d2_fabric_out_inverted <= d2_i;
      d3_fabric_out          <= d3_o;
      d3_fabric_out_inverted <= d3_i;
      d3_term_on             <= ~ctrl_r[`IOB_C_DCT_TERM_OFF];
      d4_fabric_out          <= d4_o;
      d5_fabric_out          <= d5_o;
      d5_term_on             <= ~ctrl_r[`IOB_C_DT_TERM_OFF];
      d6_fabric_out          <= d6_o;
      d6_offset_cal_enable   <= cal_r[`IOB_K_D_EN +: 2];
      d6_offset_cal_value    <= cal_r[`IOB_K_D_VAL +: 4];
      hs_receiver_out        <= hs_o;
      lp_receiver_out        <= pad_s[17:16] & {2{~ctrl_r[`IOB_C_LP_OFF]}};
      bidir_fabric_out       <= pad_s[18];
      bidir_term_on          <= tristate;
      bidir_pad_out          <= ctrl_r[`IOB_C_DOUT];
      bidir_pad_oe           <= ~tristate;
    end
  end

  // ----------------------------------------------------------------
  // Read-back views
  // ----------------------------------------------------------------
  wire [`IOB_STAT_W-1:0] stat_v;
  wire [`IOB_TERM_W-1:0] term_v;

  assign stat_v = {bidir_fabric_out, lp_receiver_out, hs_receiver_out, d6_fabric_out,
                   d5_fabric_out, d4_fabric_out, d3_fabric_out_inverted, d3_fabric_out,
                   d2_fabric_out_inverted, d2_fabric_out, d1_fabric_out_inverted,
                   d1_fabric_out, d0_fabric_out, se_cal_fabric_out, se_term_fabric_out};
  assign term_v = {bidir_term_on, d5_term_on, d3_term_on, se_term_on};

  // ----------------------------------------------------------------
  // APB slave: one wait-free access phase, read data sampled in setup, write data in the access phase
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite) begin
        if (sel_ctrl) begin
          prdata <= {{(32-`IOB_CTRL_W){1'b0}}, ctrl_r};
        end else if (sel_cal) begin
          prdata <= {{(32-`IOB_CAL_W){1'b0}}, cal_r};
        end else if (sel_stat) begin
          prdata <= {{(32-`IOB_STAT_W){1'b0}}, stat_v};
        end else if (sel_term) begin
          prdata <= {{(32-`IOB_TERM_W){1'b0}}, term_v};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end else if (psel & penable & pready) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// [tb/iob_checker.sv]
// Checker for the pad buffer control block, bound to its top-level ports.
// Assumes APB writes reach the control word lane by lane, as the shadow models.
`timescale 1ns/1ns
module iob_checker #(
  parameter USE_INPUT_OFF_ATTR = 1
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        pready,
  input wire        pslverr,
  input wire        se_term_pad,
  input wire        se_term_fabric_out,
  input wire        se_term_on,
  input wire        d4_pad,
  input wire        d4_padb,
  input wire        d4_fabric_out,
  input wire        d3_term_on,
  input wire        d5_term_on,
  input wire        dphy_pad,
  input wire        dphy_padb,
  input wire        hs_receiver_out,
  input wire        bidir_pad_out,
  input wire        bidir_pad_oe,
  input wire        bidir_term_on
);
  // ----------------------------------------------------------------
  // Control word shadow and warm-up count
  // ----------------------------------------------------------------
  reg  [12:0] ctrl_r;
  reg  [1:0]  warm_r;
  wire        wr_ctrl = psel & penable & pready & pwrite & (paddr == 12'h000);
  wire        warm    = (warm_r == 2'h3);
  wire        off_ok  = (USE_INPUT_OFF_ATTR != 0);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 13'h0200;
      warm_r <= 2'h0;
    end else begin
      if (!warm)
        warm_r <= warm_r + 2'h1;
      if (wr_ctrl && pstrb[0])
        ctrl_r[7:0] <= pwdata[7:0];
      if (wr_ctrl && pstrb[1])
        ctrl_r[12:8] <= pwdata[12:8];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_access;
    pready ##1 !pready;
  endsequence

  a_apb_one_wait: assert property (s_setup |=> s_one_access)
    else $error("access phase not one cycle");
  a_unmapped_err: assert property (pready |-> pslverr == !(paddr == 12'h000 ||
    paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00C))
    else $error("slave error flag wrong");
  a_se_off_low: assert property (warm |-> se_term_fabric_out ==
    ($past(se_term_pad, 3) && !(off_ok && $past(ctrl_r[0])))) else $error("se output wrong");
  a_se_term_own: assert property (warm |-> se_term_on == !$past(ctrl_r[1]))
    else $error("se termination wrong");
  a_diff_off_low: assert property (warm |-> d4_fabric_out == ($past(d4_pad, 3) &&
    !$past(d4_padb, 3) && !(off_ok && $past(ctrl_r[3])))) else $error("diff output wrong");
  a_diff_term_off: assert property (warm |-> d3_term_on == !$past(ctrl_r[7]) &&
    d5_term_on == !$past(ctrl_r[5])) else $error("diff termination wrong");
  a_hs_rx_off: assert property (warm |-> hs_receiver_out == ($past(dphy_pad, 3) &&
    !$past(dphy_padb, 3) && !$past(ctrl_r[10]))) else $error("hs output wrong");
  a_drv_follow: assert property (warm |-> bidir_pad_oe == !$past(ctrl_r[9]) &&
    bidir_pad_out == $past(ctrl_r[12])) else $error("driver state wrong");
  a_term_vs_drv: assert property (warm |-> bidir_term_on == $past(ctrl_r[9]) &&
    bidir_term_on != bidir_pad_oe) else $error("bidir termination wrong");
endmodule

bind iob_top iob_checker #(.USE_INPUT_OFF_ATTR(USE_INPUT_OFF_ATTR)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
  .pslverr, .se_term_pad, .se_term_fabric_out, .se_term_on, .d4_pad, .d4_padb,
  .d4_fabric_out, .d3_term_on, .d5_term_on, .dphy_pad, .dphy_padb,
  .hs_receiver_out, .bidir_pad_out, .bidir_pad_oe, .bidir_term_on
);

// [tb/iob_pad_model.sv]
// Pad-side model: external sources on every input pad and on the bidir wire.
// Assumes the bench changes pad levels just after a rising edge.
`timescale 1ns/1ns
module iob_pad_model (
  input  wire        pclk,
  input  wire [17:0] pad_cmd,
  input  wire        ext_oe,
  input  wire        ext_lvl,
  input  wire        bidir_pad_out,
  input  wire        bidir_pad_oe,
  output wire [17:0] pad_vec,
  output wire        bidir_wire
);
  reg last_r = 1'b0;

  // Inverted outputs are sampled as data only
  // D-PHY pair runs the terminated D-PHY standard
  assign pad_vec = pad_cmd;
  // Undriven wire shows the inverse of its last level
  assign bidir_wire = bidir_pad_oe ? bidir_pad_out : (ext_oe ? ext_lvl : ~last_r);

  always @(posedge pclk) begin
    last_r <= bidir_wire;
  end
endmodule

// [tb/tb_iob_top.sv]
// Self-checking bench for the pad buffer control block over APB.
// Assumes the pad model drives all pads and resolves the bidir wire.
`timescale 1ns/1ns
`include "iob_regs.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module tb_iob_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [17:0] pad_cmd = 18'h0;
  logic        ext_oe = 1'b1;
  logic        ext_lvl = 1'b0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [17:0] pv;
  wire         bw;
  wire  [20:0] fo;
  wire  [3:0]  se_val;
  wire  [3:0]  d6_val;
  wire  [1:0]  d6_en;
  wire  [1:0]  lp;
  wire  [1:0]  na_fo;
  logic [31:0] rd;
  logic        er;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #5 pclk = ~pclk;

  iob_top #(.USE_INPUT_OFF_ATTR(1)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .se_term_pad(pv[0]), .se_cal_pad(pv[1]), .d0_pad(pv[2]),
    .d0_padb(pv[3]), .d1_pad(pv[4]), .d1_padb(pv[5]), .d2_pad(pv[6]), .d2_padb(pv[7]),
    .d3_pad(pv[8]), .d3_padb(pv[9]), .d4_pad(pv[10]), .d4_padb(pv[11]), .d5_pad(pv[12]),
    .d5_padb(pv[13]), .d6_pad(pv[14]), .d6_padb(pv[15]), .dphy_pad(pv[16]),
    .dphy_padb(pv[17]), .bidir_pad_in(bw), .bidir_pad_out(fo[19]), .bidir_pad_oe(fo[20]),
    .se_term_fabric_out(fo[0]), .se_term_on(fo[1]), .se_cal_fabric_out(fo[2]),
    .se_offset_cal_enable(fo[3]), .se_offset_cal_value(se_val), .d0_fabric_out(fo[4]),
    .d1_fabric_out(fo[5]), .d1_fabric_out_inverted(fo[6]), .d2_fabric_out(fo[7]),
    .d2_fabric_out_inverted(fo[8]), .d3_fabric_out(fo[9]), .d3_fabric_out_inverted(fo[10]),
    .d3_term_on(fo[11]), .d4_fabric_out(fo[12]), .d5_fabric_out(fo[13]), .d5_term_on(fo[14]),
    .d6_fabric_out(fo[15]), .d6_offset_cal_enable(d6_en), .d6_offset_cal_value(d6_val),
    .hs_receiver_out(fo[16]), .lp_receiver_out(lp), .bidir_fabric_out(fo[17]),
    .bidir_term_on(fo[18]));

  // Same block with input-off honouring strapped away except on the D-PHY HS and LP receivers
  iob_top #(.USE_INPUT_OFF_ATTR(0)) dut_na (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
    .se_term_pad(pv[0]), .se_cal_pad(pv[1]), .d0_pad(pv[2]), .d0_padb(pv[3]),
    .d1_pad(pv[4]), .d1_padb(pv[5]), .d2_pad(pv[6]), .d2_padb(pv[7]), .d3_pad(pv[8]),
    .d3_padb(pv[9]), .d4_pad(pv[10]), .d4_padb(pv[11]), .d5_pad(pv[12]),
    .d5_padb(pv[13]), .d6_pad(pv[14]), .d6_padb(pv[15]), .dphy_pad(pv[16]),
    .dphy_padb(pv[17]), .bidir_pad_in(bw), .bidir_pad_out(), .bidir_pad_oe(),
    .se_term_fabric_out(na_fo[0]), .se_term_on(), .se_cal_fabric_out(),
    .se_offset_cal_enable(), .se_offset_cal_value(), .d0_fabric_out(), .d1_fabric_out(),
    .d1_fabric_out_inverted(), .d2_fabric_out(), .d2_fabric_out_inverted(),
    .d3_fabric_out(), .d3_fabric_out_inverted(), .d3_term_on(), .d4_fabric_out(na_fo[1]),
    .d5_fabric_out(), .d5_term_on(), .d6_fabric_out(), .d6_offset_cal_enable(),
    .d6_offset_cal_value(), .hs_receiver_out(), .lp_receiver_out(), .bidir_fabric_out(),
    .bidir_term_on());

  iob_pad_model u_pads (.pclk(pclk), .pad_cmd(pad_cmd), .ext_oe(ext_oe), .ext_lvl(ext_lvl),
    .bidir_pad_out(fo[19]), .bidir_pad_oe(fo[20]), .pad_vec(pv), .bidir_wire(bw));

  // ----------------------------------------------------------------
  // Bus and timing helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    `CHK(nm, e, rd)
  endtask

  task automatic wrc(input logic [31:0] d);
    apb(1'b1, `IOB_CTRL_OFS, d, 4'hF);
    settle(1);
  endtask

  task automatic pads(input logic [17:0] v);
    @(posedge pclk);
    pad_cmd <= v;
    settle(4);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdc("ctrl", `IOB_CTRL_OFS, 32'h0000_0200);
    rdc("cal", `IOB_CAL_OFS, 32'h0);
    rdc("term", `IOB_TERM_OFS, 32'hF);
    rdc("status", `IOB_STAT_OFS, 32'h0150);
    apb(1'b1, `IOB_TERM_OFS, 32'h0, 4'hF);
    rdc("term_ro", `IOB_TERM_OFS, 32'hF);
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    `CHK("unmapped_err", 1'b1, er)
    `CHK("unmapped_data", 32'h0, rd)
    apb(1'b0, 12'h006, 32'h0, 4'h0);
    `CHK("unaligned_err", 1'b1, er)
  endtask

  task automatic t_se;
    pads(18'h15557);
    `CHK("se_idle", 3'h7, fo[2:0])
    wrc(32'h0205);
    `CHK("se_off", 3'h2, fo[2:0])
    `CHK("se_off_na", 1'b1, na_fo[0])
    wrc(32'h0202);
    `CHK("se_term_off", 3'h5, fo[2:0])
  endtask

  task automatic t_diff;
    wrc(32'h03F8);
    `CHK("diff_off", 12'h02B, fo[15:4])
    `CHK("diff_off_na", 1'b1, na_fo[1])
    wrc(32'h0200);
    `CHK("diff_on", 12'hFAB, fo[15:4])
    pads(18'h2AAA8);
    `CHK("diff_rev", 12'h4D4, fo[15:4])
    pads(18'h15557);
  endtask

  task automatic t_cal;
    apb(1'b1, `IOB_CAL_OFS, 32'hFFFF_A3F1, 4'h3);
    settle(1);
    `CHK("se_cal", 5'h1F, {fo[3], se_val})
    `CHK("d_cal", 6'h3A, {d6_en, d6_val})
    apb(1'b1, `IOB_CAL_OFS, 32'h0, 4'h2);
    rdc("cal_lane", `IOB_CAL_OFS, 32'h0000_00F1);
    `CHK("d_cal_clr", 6'h00, {d6_en, d6_val})
  endtask

  task automatic t_dphy;
    wrc(32'h0600);
    `CHK("hs_off", 3'h1, {fo[16], lp})
    wrc(32'h0A00);
    `CHK("lp_off", 3'h4, {fo[16], lp})
    wrc(32'h0200);
  endtask

  task automatic t_bidir;
    @(posedge pclk);
    ext_lvl <= 1'b1;
    settle(4);
    `CHK("bidir_hiz", 3'h3, {fo[20], fo[18], fo[17]})
    @(posedge pclk);
    ext_oe <= 1'b0;
    wrc(32'h1000);
    `CHK("bidir_drv", 3'h6, {fo[20], fo[19], fo[18]})
    settle(3);
    `CHK("bidir_own1", 1'b1, fo[17])
    wrc(32'h0000);
    settle(3);
    `CHK("bidir_own0", 3'h4, {fo[20], fo[19], fo[17]})
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_se;
    t_diff;
    t_cal;
    t_dphy;
    t_bidir;
    close_out;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      close_out;
    end
  end
endmodule
